// File: wdi_pkg.sv
// shared constants and carrier types for the watchdog / swap instruction unit
package wdi_pkg;

  // instruction word geometry
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned NIB_W   = 4;

  // opcode values and the masks that pick the fixed bits
  localparam logic [9:0] OP_FLAG_CLEAR = 10'h0a0; // no operand
  localparam logic [9:0] OP_WDT_DIS    = 10'h29c; // no operand
  localparam logic [9:0] OP_SWAP       = 10'h2d0; // low nibble is j
  localparam logic [9:0] OP_SWAP_DEC   = 10'h2f0; // low nibble is j
  localparam logic [9:0] MASK_FULL     = 10'h3ff;
  localparam logic [9:0] MASK_IMM      = 10'h3f0;

  // decremented pointer value (y_dec) that makes the decrementing swap skip
  localparam logic [3:0] Y_SKIP_VAL = 4'hf;
  localparam logic [3:0] Y_STEP     = 4'h1;

  // one-hot sequencing states
  typedef enum logic [1:0] {
    WDI_ST_RUN  = 2'b01,
    WDI_ST_SKIP = 2'b10
  } wdi_state_e;

  // decoded instruction
  typedef struct packed {
    logic       is_flag_clear;
    logic       is_wdt_dis;
    logic       is_swap;
    logic       is_swap_dec;
    logic [3:0] imm;
  } wdi_dec_s;

  // register and memory write-back, one pulse per executed swap
  typedef struct packed {
    logic       acc_we;
    logic [3:0] acc_data;
    logic       mem_we;
    logic [3:0] mem_data;
    logic       x_we;
    logic [3:0] x_data;
    logic       y_we;
    logic [3:0] y_data;
  } wdi_wb_s;

endpackage

// File: wdi_decode.sv
// opcode decoder for the watchdog / swap instruction unit
`timescale 1ns/1ps
module wdi_decode
  import wdi_pkg::*;
(
  input  wire logic [9:0] instr,
  output wdi_dec_s        dec
);

  // a masked compare, shared by all four opcodes
  function automatic logic op_match(input logic [9:0] word,
                                    input logic [9:0] code,
                                    input logic [9:0] mask);
    op_match = ((word & mask) == code);
  endfunction

  wire logic hit_clear;
  wire logic hit_dis;
  wire logic hit_swap;
  wire logic hit_swapd;

  // fixed-bit compares; the immediate bits are don't-care for the swaps
  assign hit_clear = op_match(instr, OP_FLAG_CLEAR, MASK_FULL);
  assign hit_dis   = op_match(instr, OP_WDT_DIS, MASK_FULL);
  assign hit_swap  = op_match(instr, OP_SWAP, MASK_IMM);
  assign hit_swapd = op_match(instr, OP_SWAP_DEC, MASK_IMM);

  assign dec.is_flag_clear = hit_clear;
  assign dec.is_wdt_dis    = hit_dis;
  assign dec.is_swap       = hit_swap;
  assign dec.is_swap_dec   = hit_swapd;
  assign dec.imm           = instr[3:0];

endmodule

// File: wdi_exec.sv
// execution unit for watchdog flag clear, disable and accumulator swaps
`timescale 1ns/1ps
module wdi_exec
  import wdi_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       instr_valid,
  input  wire logic [9:0] instr,
  input  wire logic [3:0] acc,
  input  wire logic [3:0] mem_rdata,
  input  wire logic [3:0] x_ptr,
  input  wire logic [3:0] y_ptr,
  input  wire logic       watchdog_expiry_flag,
  output wdi_wb_s         wb,
  output logic            flag_clear,
  output logic            wdt_stop,
  output logic            skip_next,
  output logic            skipping
);

  wdi_dec_s   dec;
  wdi_state_e state_reg;
  wdi_state_e state_next;
  logic       dis_prev_reg;
  logic       dis_prev_next;
  wdi_wb_s    wb_reg;
  wdi_wb_s    wb_next;
  logic       flag_clear_reg;
  logic       wdt_stop_reg;
  logic       skip_reg;

  wire logic       exec;
  wire logic       any_swap;
  wire logic       clear_skip;
  wire logic       dec_skip;
  wire logic       do_stop;
  wire logic [3:0] y_dec;

  wdi_decode u_decode (
    .instr (instr),
    .dec   (dec)
  );

  // an instruction is only carried out outside a skip slot
  assign exec       = instr_valid && (state_reg == WDI_ST_RUN);
  assign any_swap   = exec && (dec.is_swap || dec.is_swap_dec);
  assign y_dec      = y_ptr - Y_STEP; // wraps 0 -> 15 on purpose
  assign clear_skip = exec && dec.is_flag_clear
                      && watchdog_expiry_flag;
  assign dec_skip   = exec && dec.is_swap_dec
                      && (y_dec == Y_SKIP_VAL);
  assign do_stop    = exec && dec.is_flag_clear && dis_prev_reg;

  // skip sequencing: the slot after a skipping instruction runs as a nop
  always_comb begin
    state_next = state_reg;
    if (instr_valid) begin
      if (clear_skip || dec_skip) begin
        state_next = WDI_ST_SKIP;
      end else begin
        state_next = WDI_ST_RUN;
      end
    end
  end

  // only an executed disable arms the stop; a skipped one does not count
  always_comb begin
    dis_prev_next = dis_prev_reg;
    if (instr_valid) begin
      dis_prev_next = exec && dec.is_wdt_dis;
    end
  end

  // write-back values; the old operands are captured in the same cycle,
  // so both directions of the exchange see pre-swap data
  always_comb begin
    wb_next          = '0;
    wb_next.acc_we   = any_swap;
    wb_next.acc_data = mem_rdata;
    wb_next.mem_we   = any_swap;
    wb_next.mem_data = acc;
    wb_next.x_we     = any_swap;
    wb_next.x_data   = x_ptr ^ dec.imm;
    wb_next.y_we     = exec && dec.is_swap_dec;
    wb_next.y_data   = y_dec;
  end

  // state registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg    <= WDI_ST_RUN;
      dis_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      dis_prev_reg <= dis_prev_next;
    end
  end

  // output pulses, one cycle after the instruction strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb_reg         <= '0;
      flag_clear_reg <= 1'b0;
      wdt_stop_reg   <= 1'b0;
      skip_reg       <= 1'b0;
    end else begin
      wb_reg         <= wb_next;
      flag_clear_reg <= clear_skip;
      wdt_stop_reg   <= do_stop;
      skip_reg       <= clear_skip || dec_skip;
    end
  end

  assign wb         = wb_reg;
  assign flag_clear = flag_clear_reg;
  assign wdt_stop   = wdt_stop_reg;
  assign skip_next  = skip_reg;
  assign skipping   = (state_reg == WDI_ST_SKIP);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  flag_set_clear_a: assert property (
    (exec && dec.is_flag_clear && watchdog_expiry_flag)
    |=> (flag_clear && skip_next) ##1 (!flag_clear || skipping))
    else $error("set expiry flag not cleared with skip");

  flag_zero_run_a: assert property (
    (exec && dec.is_flag_clear && !watchdog_expiry_flag)
    |=> (!flag_clear && !skip_next && !skipping))
    else $error("flag clear acted on a zero flag");

  wdt_stop_seq_a: assert property (
    wdt_stop |-> $past(exec && dec.is_flag_clear)
                 && $past(dis_prev_reg))
    else $error("watchdog stop without disable then clear");

  wdt_stop_hit_a: assert property (
    (exec && dec.is_wdt_dis)
    ##1 (instr_valid && !skipping && dec.is_flag_clear)
    |=> wdt_stop)
    else $error("disable then clear did not stop watchdog");

  swap_both_ways_a: assert property (
    any_swap |=> (wb.acc_we && wb.mem_we
                  && wb.acc_data == $past(mem_rdata)
                  && wb.mem_data == $past(acc)))
    else $error("accumulator memory exchange wrong");

  x_xor_imm_a: assert property (
    any_swap |=> (wb.x_we && wb.x_data == ($past(x_ptr) ^ $past(instr[3:0]))))
    else $error("x pointer not xored with immediate");

  y_dec_skip_a: assert property (
    (exec && dec.is_swap_dec)
    |=> (wb.y_we && wb.y_data == $past(y_ptr) - 4'h1
         && skip_next == ($past(y_ptr) == 4'h0)))
    else $error("y decrement or skip wrong");

  skip_no_update_a: assert property (
    (instr_valid && skipping)
    |=> (!wb.acc_we && !wb.mem_we && !wb.x_we && !wb.y_we
         && !flag_clear && !wdt_stop && !skip_next && !skipping))
    else $error("skipped instruction made an update");

endmodule

// File: wdt_reset_mem_exchange_instrs_tb.sv
// self-checking bench for the watchdog flag clear and swap execution unit
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
  end end
module wdt_reset_mem_exchange_instrs_tb;
  import wdi_pkg::*;
  logic       clock       = 1'b0;
  logic       arst_n      = 1'b0;
  logic       instr_valid = 1'b0;
  logic       flag        = 1'b0;
  logic [9:0] instr       = 10'h000;
  logic [3:0] acc         = 4'h0;
  logic [3:0] mem         = 4'h0;
  logic [3:0] x           = 4'h0;
  logic [3:0] y           = 4'h0;
  wdi_wb_s    wb;
  logic       flag_clear;
  logic       wdt_stop;
  logic       skip_next;
  logic       skipping;
  int         mismatches   = 0;
  int         total_checks = 0;
  wdi_wb_s    none         = '0;

  wdi_exec i_dut (.clock(clock), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr(instr), .acc(acc), .mem_rdata(mem), .x_ptr(x), .y_ptr(y),
    .watchdog_expiry_flag(flag), .wb(wb), .flag_clear(flag_clear),
    .wdt_stop(wdt_stop), .skip_next(skip_next), .skipping(skipping));

  // free-running 50 MHz clock
  always #10 clock = ~clock;

  // data without its write enable is don't-care, so blank it on both sides
  function automatic wdi_wb_s msk(wdi_wb_s w);
    if (!w.acc_we) w.acc_data = 4'h0;
    if (!w.mem_we) w.mem_data = 4'h0;
    if (!w.x_we) w.x_data = 4'h0;
    if (!w.y_we) w.y_data = 4'h0;
    return w;
  endfunction

  // expected write-back of a swap, worked out from the operands
  function automatic wdi_wb_s swp(logic [3:0] a, m, xp, j, yp, logic dec);
    return '{1'b1, m, 1'b1, a, 1'b1, xp ^ j, dec, yp - 4'h1};
  endfunction

  // one instruction slot; valid stays high so slots can run back to back
  task automatic slot(logic [9:0] op, logic [3:0] a, m, xp, yp, logic f);
    instr_valid = 1'b1;
    instr = op;
    acc = a;
    mem = m;
    x = xp;
    y = yp;
    flag = f;
    @(posedge clock);
    #1;
  endtask

  task automatic idle();
    instr_valid = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // ev packs flag_clear, wdt_stop, skip_next, skipping
  task automatic chk(wdi_wb_s ew, logic [3:0] ev);
    `CHK("wb", msk(ew), msk(wb))
    `CHK("ctl", ev, {flag_clear, wdt_stop, skip_next, skipping})
  endtask

  // every immediate value, back to back
  task automatic t_swap();
    for (int j = 0; j < 16; j++) begin
      slot(OP_SWAP | 10'(j), 4'(j), ~4'(j), 4'h6, 4'h2, 1'b0);
      chk(swp(4'(j), ~4'(j), 4'h6, 4'(j), 4'h2, 1'b0), 4'h0);
    end
    idle();
    chk(none, 4'h0);
  endtask

  // y wraps to 15 and skips; the skipped slot writes nothing
  task automatic t_swap_dec();
    slot(OP_SWAP_DEC | 10'h005, 4'h3, 4'h9, 4'h6, 4'h0, 1'b0);
    chk(swp(4'h3, 4'h9, 4'h6, 4'h5, 4'h0, 1'b1), 4'h3);
    slot(OP_SWAP | 10'h001, 4'h1, 4'h2, 4'h3, 4'h4, 1'b1);
    chk(none, 4'h0);
    slot(OP_SWAP_DEC | 10'h00a, 4'hc, 4'h5, 4'hf, 4'h4, 1'b0);
    chk(swp(4'hc, 4'h5, 4'hf, 4'ha, 4'h4, 1'b1), 4'h0);
    idle();
  endtask

  // set flag clears and skips, a clear flag does neither
  task automatic t_flag();
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
    chk(none, 4'hb);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
    chk(none, 4'h0);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    idle();
  endtask

  // stop only when the clear follows an executed disable directly
  task automatic t_stop();
    slot(OP_WDT_DIS, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
    chk(none, 4'hf);
    // this disable lands in the skip slot, so it must not arm the stop
    slot(OP_WDT_DIS, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    slot(OP_WDT_DIS, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h4);
    slot(OP_WDT_DIS, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    slot(OP_SWAP, 4'h7, 4'h8, 4'h1, 4'h0, 1'b0);
    chk(swp(4'h7, 4'h8, 4'h1, 4'h0, 4'h0, 1'b0), 4'h0);
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    chk(none, 4'h0);
    idle();
  endtask

  // reset in mid-run drops a pending skip and all pulses
  task automatic t_reset();
    slot(OP_FLAG_CLEAR, 4'h0, 4'h0, 4'h0, 4'h0, 1'b1);
    chk(none, 4'hb);
    arst_n = 1'b0;
    idle();
    chk(none, 4'h0);
    arst_n = 1'b1;
    slot(OP_SWAP | 10'h00c, 4'h2, 4'hd, 4'h9, 4'h1, 1'b0);
    chk(swp(4'h2, 4'hd, 4'h9, 4'hc, 4'h1, 1'b0), 4'h0);
    idle();
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // the tests need well under a hundred cycles; this cuts a hang short
  initial begin
    #(2000 * 20);
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (5) @(posedge clock);
    #1;
    arst_n = 1'b1;
    chk(none, 4'h0);
    t_swap();
    t_swap_dec();
    t_flag();
    t_stop();
    t_reset();
    end_of_test();
  end
endmodule
